// [core/bur_pkg.sv]
/*
  bur_pkg: constants for the banked serial register file.
  Assumes a single 200 MHz system clock and an 8-bit host data bus.
*/
package bur_pkg;
  localparam int unsigned BUR_BANKS      = 4;
  localparam int unsigned BUR_SLOTS      = 8;
  localparam int unsigned BUR_REG_COUNT  = 35;
  // slot offsets within a bank
  localparam logic [2:0] OFF_DATA        = 3'h0;
  localparam logic [2:0] OFF_GIE         = 3'h1;
  localparam logic [2:0] OFF_DIV_LOW     = 3'h0;
  localparam logic [2:0] OFF_DIV_HIGH    = 3'h1;
  localparam logic [2:0] OFF_IDENT_BANK  = 3'h2;
  localparam logic [2:0] OFF_LINE_CTRL   = 3'h3;
  localparam logic [2:0] OFF_MODEM_CTRL  = 3'h4;
  localparam logic [2:0] OFF_LINE_STAT   = 3'h5;
  localparam logic [2:0] OFF_MODEM_STAT  = 3'h6;
  localparam logic [2:0] OFF_CHAR_CMP0   = 3'h7;
  // field positions
  localparam int unsigned DIVISOR_LATCH_ACCESS_BIT_BIT       = 7;
  localparam int unsigned BANK_PTR_LSB   = 5;
  // bank numbers
  localparam logic [1:0] BANK_COMPAT     = 2'h0;
  localparam logic [1:0] BANK_MODEM_CONF = 2'h3;
  // reset values
  localparam logic [7:0] RST_DIV_LOW     = 8'h02;
  localparam logic [7:0] RST_DIV_HIGH    = 8'h00;
  localparam logic [7:0] RST_GIE         = 8'h00;
  localparam logic [7:0] RST_IDENT       = 8'h01;
  localparam logic [7:0] RST_LINE_CTRL   = 8'h00;
  localparam logic [7:0] RST_MODEM_CTRL  = 8'h00;
  localparam logic [7:0] RST_LINE_STAT   = 8'h60;
  localparam logic [7:0] RST_MODEM_STAT  = 8'h00;
  localparam logic [7:0] RST_CHAR_CMP0   = 8'h00;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  // writable masks
  localparam logic [7:0] GIE_MASK        = 8'h3F;
  localparam logic [7:0] MCR_MASK        = 8'h3F;
  localparam logic [7:0] STORE_MASK      = 8'hFF;
endpackage

// [core/bur_regs.sv]
/*
  bur_regs: host-facing banked register file of the serial controller.
  Assumes host signals are synchronous to clk_sys_i (logic on the same
  clock); status words come from the serial machines on that clock.
*/
`timescale 1ns/1ps
module bur_regs
  import bur_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  // host register port
  input  wire logic [2:0] register_address_lines_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // serial machine side
  input  wire logic [7:0] rx_data_i,
  input  wire logic [3:0] int_ident_i,
  input  wire logic [7:0] line_status_i,
  input  wire logic [7:0] modem_status_i,
  input  wire logic [7:0] bank_rd_i [1:3][0:7],
  output logic            tx_write_o,
  output logic      [7:0] tx_data_o,
  output logic      [1:0] bank_pointer_field_o,
  output logic      [2:0] bank_wr_slot_o,
  output logic      [1:0] bank_wr_bank_o,
  output logic            bank_wr_o,
  output logic      [7:0] bank_wdata_o,
  output logic      [7:0] divisor_a_o [0:1],
  output logic      [7:0] divisor_b_o [0:1],
  output logic      [7:0] line_control_o,
  output logic      [7:0] modem_control_o,
  output logic      [7:0] general_interrupt_enable_o,
  output logic      [7:0] control_char_compare_zero_o,
  output logic            rx_read_o
);

  typedef enum logic [1:0] {
    SEL_PLAIN = 2'b00,
    SEL_DIV   = 2'b01
  } bur_sel_type;

  logic [1:0] bank_q, bank_d;
  logic [7:0] div_a_q [0:1];
  logic [7:0] div_a_d [0:1];
  logic [7:0] div_b_q [0:1];
  logic [7:0] div_b_d [0:1];
  logic [7:0] lcr_q, lcr_d, mcr_q, mcr_d, gie_q, gie_d, cmp_q, cmp_d;
  logic [7:0] tx_q, tx_d, rdata_q, rdata_d;
  logic       txw_q, txw_d, rxr_q, rxr_d;
  logic       bw_q, bw_d;
  logic [2:0] bslot_q, bslot_d;
  logic [1:0] bbank_q, bbank_d;
  logic [7:0] bdata_q, bdata_d;
  bur_sel_type sel;

  // slots 0 and 1 divert to divisors only in banks 0 and 3
  function automatic bur_sel_type slot_sel(input logic [1:0] bank,
                                           input logic [2:0] slot,
                                           input logic       divisor_latch_access_bit);
    if (divisor_latch_access_bit && (bank == BANK_COMPAT || bank == BANK_MODEM_CONF) &&
        (slot == OFF_DIV_LOW || slot == OFF_DIV_HIGH)) begin
      return SEL_DIV;
    end
    return SEL_PLAIN;
  endfunction

  always_comb begin
    sel     = slot_sel(bank_q, register_address_lines_i,
                       lcr_q[DIVISOR_LATCH_ACCESS_BIT_BIT]);
    bank_d  = bank_q;
    div_a_d = div_a_q;
    div_b_d = div_b_q;
    lcr_d   = lcr_q;
    mcr_d   = mcr_q;
    gie_d   = gie_q;
    cmp_d   = cmp_q;
    tx_d    = tx_q;
    txw_d   = 1'b0;
    rxr_d   = 1'b0;
    bw_d    = 1'b0;
    bslot_d = bslot_q;
    bbank_d = bbank_q;
    bdata_d = bdata_q;
    rdata_d = rdata_q;
    if (wr_i) begin
      // ident slot sits in every bank, so a bank switch is always possible
      if (register_address_lines_i == OFF_IDENT_BANK) begin
        bank_d = wdata_i[BANK_PTR_LSB +: 2];
      end else if (sel == SEL_DIV) begin
        if (bank_q == BANK_COMPAT) begin
          div_a_d[register_address_lines_i[0]] = wdata_i;
        end else begin
          div_b_d[register_address_lines_i[0]] = wdata_i;
        end
      end else if (bank_q == BANK_COMPAT) begin
        case (register_address_lines_i)
          OFF_DATA: begin
            tx_d  = wdata_i;
            txw_d = 1'b1;
          end
          OFF_GIE:        gie_d = wdata_i & GIE_MASK;
          OFF_LINE_CTRL:  lcr_d = wdata_i & STORE_MASK;
          OFF_MODEM_CTRL: mcr_d = wdata_i & MCR_MASK;
          OFF_CHAR_CMP0:  cmp_d = wdata_i;
          default:        bw_d  = 1'b0;
        endcase
      end else begin
        // other banks handed to their own blocks
        bw_d    = 1'b1;
        bslot_d = register_address_lines_i;
        bbank_d = bank_q;
        bdata_d = wdata_i;
      end
    end
    if (rd_i) begin
      if (register_address_lines_i == OFF_IDENT_BANK) begin
        rdata_d = {1'b0, bank_q, 1'b0, int_ident_i};
      end else if (sel == SEL_DIV) begin
        rdata_d = (bank_q == BANK_COMPAT) ?
                  div_a_q[register_address_lines_i[0]] :
                  div_b_q[register_address_lines_i[0]];
      end else if (bank_q == BANK_COMPAT) begin
        case (register_address_lines_i)
          OFF_DATA: begin
            rdata_d = rx_data_i;
            rxr_d   = 1'b1;
          end
          OFF_GIE:        rdata_d = gie_q;
          OFF_LINE_CTRL:  rdata_d = lcr_q;
          OFF_MODEM_CTRL: rdata_d = mcr_q;
          OFF_LINE_STAT:  rdata_d = line_status_i;
          OFF_MODEM_STAT: rdata_d = modem_status_i;
          OFF_CHAR_CMP0:  rdata_d = cmp_q;
          default:        rdata_d = RST_ZERO;
        endcase
      end else begin
        rdata_d = bank_rd_i[bank_q][register_address_lines_i];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      bank_q     <= RST_IDENT[BANK_PTR_LSB +: 2];
      div_a_q[0] <= RST_DIV_LOW;
      div_a_q[1] <= RST_DIV_HIGH;
      div_b_q[0] <= RST_DIV_LOW;
      div_b_q[1] <= RST_DIV_HIGH;
      lcr_q      <= RST_LINE_CTRL;
      mcr_q      <= RST_MODEM_CTRL;
      gie_q      <= RST_GIE;
      cmp_q      <= RST_CHAR_CMP0;
      tx_q       <= RST_ZERO;
      rdata_q    <= RST_ZERO;
      txw_q      <= 1'b0;
      rxr_q      <= 1'b0;
      bw_q       <= 1'b0;
      bslot_q    <= 3'h0;
      bbank_q    <= 2'h0;
      bdata_q    <= RST_ZERO;
    end else begin
      bank_q  <= bank_d;
      div_a_q <= div_a_d;
      div_b_q <= div_b_d;
      lcr_q   <= lcr_d;
      mcr_q   <= mcr_d;
      gie_q   <= gie_d;
      cmp_q   <= cmp_d;
      tx_q    <= tx_d;
      rdata_q <= rdata_d;
      txw_q   <= txw_d;
      rxr_q   <= rxr_d;
      bw_q    <= bw_d;
      bslot_q <= bslot_d;
      bbank_q <= bbank_d;
      bdata_q <= bdata_d;
    end
  end

  assign rdata_o                     = rdata_q;
  assign tx_write_o                  = txw_q;
  assign tx_data_o                   = tx_q;
  assign rx_read_o                   = rxr_q;
  assign bank_pointer_field_o        = bank_q;
  assign bank_wr_o                   = bw_q;
  assign bank_wr_slot_o              = bslot_q;
  assign bank_wr_bank_o              = bbank_q;
  assign bank_wdata_o                = bdata_q;
  assign divisor_a_o                 = div_a_q;
  assign divisor_b_o                 = div_b_q;
  assign line_control_o              = lcr_q;
  assign modem_control_o             = mcr_q;
  assign general_interrupt_enable_o  = gie_q;
  assign control_char_compare_zero_o = cmp_q;

  bank_switch_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && register_address_lines_i == OFF_IDENT_BANK |=>
    bank_pointer_field_o == $past(wdata_i[6:5]))
    else $error("bank pointer not taken from write");
  bank_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !(wr_i && register_address_lines_i == OFF_IDENT_BANK) |=>
    $stable(bank_pointer_field_o))
    else $error("bank pointer moved without a write");
  ident_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && register_address_lines_i == OFF_IDENT_BANK |=>
    rdata_o[6:5] == $past(bank_pointer_field_o))
    else $error("ident read lost bank pointer");
  div_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && line_control_o[7] && bank_pointer_field_o == 2'h0 &&
    register_address_lines_i == 3'h0 |=>
    divisor_a_o[0] == $past(wdata_i) && !tx_write_o)
    else $error("latch write missed low divisor");
  tx_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && !line_control_o[7] && bank_pointer_field_o == 2'h0 &&
    register_address_lines_i == 3'h0 |=>
    tx_write_o && tx_data_o == $past(wdata_i))
    else $error("data write did not reach transmitter");
  other_bank_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_i && bank_pointer_field_o == 2'h1 &&
    register_address_lines_i != 3'h2 |=>
    bank_wr_o && $stable(line_control_o) && $stable(divisor_a_o[0]))
    else $error("hidden bank register changed");
  bank_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && bank_pointer_field_o == 2'h2 &&
    register_address_lines_i == 3'h4 |=>
    rdata_o == $past(bank_rd_i[2][4]))
    else $error("bank two read mismatch");
  lsr_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rd_i && bank_pointer_field_o == 2'h0 &&
    register_address_lines_i == 3'h5 |=>
    rdata_o == $past(line_status_i) ##1 1'b1)
    else $error("line status read mismatch");
endmodule

// [bench/bur_host.sv]
/*
  bur_host: host processor model on the parallel register port.
  Assumes the bench calls its tasks one at a time on clk_sys_i.
*/
`timescale 1ns/1ps
module bur_host (
  // clock
  input  wire logic       clk_sys_i,
  // host register port
  output logic      [2:0] addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o
);
  localparam logic [2:0] OFF_BANK = 3'h2;
  initial begin
    addr_o = 3'h0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // one strobe cycle; idle data flips so stale bytes never look valid
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge clk_sys_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic sel_bank(input logic [1:0] b);
    acc(1'b1, OFF_BANK, {1'b0, b, 5'h00});
  endtask
endmodule

// [bench/bur_regs_tb.sv]
/*
  bur_regs_tb: self-checking bench for the banked register file.
  Assumes the one-cycle read and pulse latency of the register port.
*/
`timescale 1ns/1ps
module bur_regs_tb;
  import bur_pkg::*;
  logic       clk_sys_i, rstn_i, rd_i, wr_i, tx_write_o, bank_wr_o;
  logic       rx_read_o;
  logic [2:0] addr, bank_wr_slot_o;
  logic [1:0] bank_o, bank_wr_bank_o;
  logic [3:0] int_ident_i;
  logic [7:0] wdata_i, rdata_o, rx_data_i, line_status_i, modem_status_i;
  logic [7:0] tx_data_o, bank_wdata_o, lcr_o, mcr_o, gie_o, acr_o;
  logic [7:0] bank_rd_i [1:3][0:7];
  logic [7:0] div_a [0:1];
  logic [7:0] div_b [0:1];
  int         num_errors, n_checks, seed, b, s;
  logic [7:0] v, dah;
  int         mdl [0:7];
  int         slots [0:2] = '{1, 4, 7};
  int         masks [0:2] = '{GIE_MASK, MCR_MASK, STORE_MASK};

  bur_host i_host (.clk_sys_i(clk_sys_i), .addr_o(addr), .rd_o(rd_i),
                   .wr_o(wr_i), .wdata_o(wdata_i));
  bur_regs i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .register_address_lines_i(addr), .rd_i(rd_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rx_data_i(rx_data_i),
    .int_ident_i(int_ident_i), .line_status_i(line_status_i),
    .modem_status_i(modem_status_i), .bank_rd_i(bank_rd_i),
    .tx_write_o(tx_write_o), .tx_data_o(tx_data_o),
    .bank_pointer_field_o(bank_o), .bank_wr_slot_o(bank_wr_slot_o),
    .bank_wr_bank_o(bank_wr_bank_o), .bank_wr_o(bank_wr_o),
    .bank_wdata_o(bank_wdata_o), .divisor_a_o(div_a),
    .divisor_b_o(div_b), .line_control_o(lcr_o),
    .modem_control_o(mcr_o), .general_interrupt_enable_o(gie_o),
    .control_char_compare_zero_o(acr_o), .rx_read_o(rx_read_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    i_host.acc(1'b0, a, 8'h00);
    chk("rdata", e, rdata_o);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
  initial begin
    seed = 32'h1e13;
    rstn_i = 1'b0;
    rx_data_i = $random(seed);
    int_ident_i = $random(seed);
    line_status_i = $random(seed);
    modem_status_i = $random(seed);
    for (b = 1; b < 4; b++)
      for (s = 0; s < 8; s++) bank_rd_i[b][s] = $random(seed);
    for (s = 0; s < 8; s++) mdl[s] = 0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    chk("div_a_lo", RST_DIV_LOW, div_a[0]);
    rdc(OFF_IDENT_BANK, {4'h0, int_ident_i});
    rdc(OFF_LINE_STAT, line_status_i);
    rdc(OFF_MODEM_STAT, modem_status_i);
    for (s = 1; s < 8; s += 2)
      rdc(s[2:0], (s == 5) ? line_status_i : 8'h00);
    $display("test reset done");
    for (s = 0; s < 3; s++) begin
      v = $random(seed);
      mdl[slots[s]] = v & masks[s];
      i_host.acc(1'b1, slots[s][2:0], v);
      rdc(slots[s][2:0], mdl[slots[s]][7:0]);
    end
    chk("gie", mdl[1][7:0], gie_o);
    chk("mcr", mdl[4][7:0], mcr_o);
    chk("acr", mdl[7][7:0], acr_o);
    i_host.acc(1'b1, OFF_LINE_STAT, v);
    rdc(OFF_LINE_STAT, line_status_i);
    i_host.acc(1'b1, OFF_DATA, v);
    chk("tx_write", 8'h01, {7'h00, tx_write_o});
    chk("tx_data", v, tx_data_o);
    rdc(OFF_DATA, rx_data_i);
    chk("rx_read", 8'h01, {7'h00, rx_read_o});
    $display("test store done");
    i_host.acc(1'b1, OFF_LINE_CTRL, 8'h80);
    chk("lcr", 8'h80, lcr_o);
    i_host.acc(1'b1, OFF_DIV_LOW, v);
    chk("tx_write", 8'h00, {7'h00, tx_write_o});
    dah = ~v;
    i_host.acc(1'b1, OFF_DIV_HIGH, dah);
    chk("div_a_hi", dah, div_a[1]);
    rdc(OFF_DIV_LOW, v);
    rdc(OFF_CHAR_CMP0, mdl[7][7:0]);
    $display("test divisor done");
    for (b = 1; b < 4; b++) begin
      i_host.sel_bank(b[1:0]);
      chk("bank", b[7:0], {6'h00, bank_o});
      rdc(OFF_IDENT_BANK, {1'b0, b[1:0], 1'b0, int_ident_i});
      // bank 3 slots 0,1 are divisors while the latch bit is set
      for (s = (b == 3) ? 3 : 0; s < 8; s++)
        if (s != 2) rdc(s[2:0], bank_rd_i[b][s]);
      v = $random(seed);
      i_host.acc(1'b1, OFF_LINE_CTRL, v);
      chk("bank_wr", 8'h01, {7'h00, bank_wr_o});
      chk("wr_bank", b[7:0], {6'h00, bank_wr_bank_o});
      chk("wr_data", v, bank_wdata_o);
      chk("wr_slot", {5'h00, OFF_LINE_CTRL}, {5'h00, bank_wr_slot_o});
    end
    rdc(OFF_DIV_HIGH, RST_DIV_HIGH);
    i_host.acc(1'b1, OFF_DIV_LOW, v);
    chk("div_b_lo", v, div_b[0]);
    chk("div_a_hi", dah, div_a[1]);
    i_host.sel_bank(BANK_COMPAT);
    rdc(OFF_LINE_CTRL, 8'h80);
    $display("test banks done");
    @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    chk("bank", {6'h00, BANK_COMPAT}, {6'h00, bank_o});
    chk("lcr", RST_LINE_CTRL, lcr_o);
    chk("div_b_lo", RST_DIV_LOW, div_b[0]);
    rdc(OFF_IDENT_BANK, {4'h0, int_ident_i});
    rdc(OFF_LINE_CTRL, RST_LINE_CTRL);
    $display("test second reset done");
    wrap_up();
  end
endmodule
